// ==== design/ttw_top.sv ====
// Eight-bit tick timer and watchdog with core-facing register port.
// Assumes inputs synchronous to CLK_SYS and single-cycle strobes.
`timescale 1ns/1ps
module ttw_top #(
    parameter int TICK_DIV   = ttw_pkg::TICK_CYCLES,
    parameter int WDOG_WIDTH = 8
) (
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    // Register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR_STB,
    input  wire logic        RD_STB,
    output logic      [7:0]  RDATA,
    // Watchdog pins and core signals
    input  wire logic        WDOG_EN_PIN,
    input  wire logic        WDOG_CLEAR,
    output logic             WDOG_RESET_OUT,
    // Interrupt
    output logic             IRQ
);
    import ttw_pkg::*;

    // Register state
    logic [7:0]  control_reg;
    logic [7:0]  count_reg;
    logic [7:0]  status_reg;
    logic [7:0]  irq_flag_reg;
    logic [7:0]  irq_ena_reg;
    logic        strobe_pulse_reg;

    // Timebase and timer tap detect
    logic [15:0] tick_div_reg;
    logic        tick;
    logic        tap_prev_reg;
    logic        tap_now;

    // Watchdog prescaler, counter two and sequencer
    logic [7:0]  wd_pre_reg;
    logic        wd_tap_prev_reg;
    logic        wd_tap_now;
    logic [WDOG_WIDTH-1:0] wd_cnt_reg;
    logic        wd_ovf;
    logic [7:0]  wd_hold_reg;
    logic        wd_rst;
    ttw_wd_state_t wd_state_reg;

    // Bus decode and events
    logic        wr_ctl;
    logic        wr_sts;
    logic        wr_flg;
    logic        timer_evt;
    logic        to_evt;

    assign wr_ctl = WR_STB && (ADDR == OFS_CONTROL);
    assign wr_sts = WR_STB && (ADDR == OFS_STATUS);
    assign wr_flg = WR_STB && (ADDR == OFS_IRQ_FLG);
    assign wd_rst = (wd_state_reg == WD_RESET);

    // Timebase tick divider
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            tick_div_reg <= 16'h0000;
        end else if (tick_div_reg == 16'(TICK_DIV - 1)) begin
            tick_div_reg <= 16'h0000;
        end else begin
            tick_div_reg <= tick_div_reg + 16'h0001;
        end
    end
    assign tick = (tick_div_reg == 16'(TICK_DIV - 1));

    // Control register; bit 7 always reads as one
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            control_reg      <= RST_CONTROL;
            strobe_pulse_reg <= 1'b0;
        end else if (wd_rst) begin
            control_reg      <= RST_CONTROL;
            strobe_pulse_reg <= 1'b0;
        end else begin
            strobe_pulse_reg <= wr_ctl && !WDATA[CTL_STROBE_BIT];
            if (wr_ctl) begin
                control_reg <= {1'b1, WDATA[6:0]};
            end
        end
    end

    // Eight-bit counter; writes to its offset are ignored
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            count_reg <= RST_ZERO;
        end else if (wd_rst) begin
            count_reg <= RST_ZERO;
        end else if (strobe_pulse_reg) begin
            count_reg <= RST_ZERO;
        end else if (control_reg[CTL_ENABLE_BIT] && tick) begin
            count_reg <= count_reg + 8'h01;
        end
    end

    // Tap edge detect for the timer interrupt
    assign tap_now   = count_reg[control_reg[CTL_ITAP_LSB +: 3]];
    assign timer_evt = tap_now && !tap_prev_reg
                       && control_reg[CTL_ENABLE_BIT];
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            tap_prev_reg <= 1'b0;
        end else begin
            tap_prev_reg <= tap_now;
        end
    end

    // Watchdog prescaler and counter two, run only with the pin high
    assign wd_tap_now = wd_pre_reg[control_reg[CTL_WTAP_LSB +: 3]];
    assign wd_ovf     = (wd_state_reg == WD_RUN) && wd_tap_now
                        && !wd_tap_prev_reg && (&wd_cnt_reg);
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            wd_pre_reg      <= 8'h00;
            wd_tap_prev_reg <= 1'b0;
            wd_cnt_reg      <= '0;
        end else if (wd_state_reg != WD_RUN) begin
            wd_pre_reg      <= 8'h00;
            wd_tap_prev_reg <= 1'b0;
            wd_cnt_reg      <= '0;
        end else begin
            wd_pre_reg      <= wd_pre_reg + 8'h01;
            wd_tap_prev_reg <= wd_tap_now;
            if (WDOG_CLEAR) begin
                wd_cnt_reg <= '0;
            end else if (wd_tap_now && !wd_tap_prev_reg) begin
                wd_cnt_reg <= wd_cnt_reg + 1'b1;
            end
        end
    end

    // Watchdog sequencer and reset pulse length
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            wd_state_reg <= WD_IDLE;
            wd_hold_reg  <= 8'h00;
        end else begin
            case (wd_state_reg)
                WD_IDLE: begin
                    if (WDOG_EN_PIN) begin
                        wd_state_reg <= WD_RUN;
                    end
                end
                WD_RUN: begin
                    if (!WDOG_EN_PIN) begin
                        wd_state_reg <= WD_IDLE;
                    end else if (wd_ovf && !WDOG_CLEAR) begin
                        wd_state_reg <= WD_RESET;
                        wd_hold_reg  <= 8'(WRST_CYCLES - 1);
                    end
                end
                WD_RESET: begin
                    if (wd_hold_reg == 8'h00) begin
                        wd_state_reg <= WD_IDLE;
                    end else begin
                        wd_hold_reg <= wd_hold_reg - 8'h01;
                    end
                end
                default: begin
                    wd_state_reg <= WD_IDLE;
                end
            endcase
        end
    end

    // Reset output straight from a flop
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            WDOG_RESET_OUT <= 1'b0;
        end else begin
            WDOG_RESET_OUT <= (wd_state_reg == WD_RUN) && wd_ovf
                              && WDOG_EN_PIN && !WDOG_CLEAR;
        end
    end
    assign to_evt = (wd_state_reg == WD_RUN) && wd_ovf && WDOG_EN_PIN
                    && !WDOG_CLEAR;

    // Status: timeout set wins over a write; all bits writable, timeout too
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            status_reg <= RST_STATUS;
        end else if (to_evt || wd_rst) begin
            status_reg[STS_TO_BIT] <= 1'b1;
        end else if (wr_sts) begin
            status_reg <= WDATA;
        end
    end

    // Interrupt flags: set wins, write one clears
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            irq_flag_reg <= RST_ZERO;
        end else if (wd_rst) begin
            irq_flag_reg <= RST_ZERO;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (wr_flg && WDATA[i]) begin
                    irq_flag_reg[i] <= 1'b0;
                end
            end
            if (timer_evt) begin
                irq_flag_reg[IRQ_TIMER_BIT] <= 1'b1;
            end
            if (to_evt) begin
                irq_flag_reg[IRQ_WDOG_BIT] <= 1'b1;
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            irq_ena_reg <= RST_ZERO;
        end else if (wd_rst) begin
            irq_ena_reg <= RST_ZERO;
        end else if (WR_STB && (ADDR == OFS_IRQ_ENA)) begin
            irq_ena_reg <= WDATA;
        end
    end

    // Interrupt output from a flop
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_flag_reg & irq_ena_reg);
        end
    end

    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            RDATA <= 8'h00;
        end else if (RD_STB) begin
            case (ADDR)
                OFS_STATUS:  RDATA <= status_reg;
                OFS_IRQ_FLG: RDATA <= irq_flag_reg;
                OFS_IRQ_ENA: RDATA <= irq_ena_reg;
                OFS_COUNT:   RDATA <= count_reg;
                OFS_CONTROL: RDATA <= control_reg;
                default:     RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    // Checks share the system clock and are off during reset
    default clocking cb_check @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);

    // Strobe write: pulse one edge later, counter zero the edge after
    a_strobe_clears_cnt: assert property (
        (wr_ctl && !WDATA[CTL_STROBE_BIT] && !wd_rst)
        |=> ##1 (count_reg == RST_ZERO))
        else $error("Counter not cleared after strobe write");

    // Control bit 7 never keeps a written zero
    a_ctl_bit7_one: assert property (
        wr_ctl |=> control_reg[CTL_STROBE_BIT])
        else $error("Control bit 7 not one");

    // Counter frozen while disabled and no clear pending
    a_count_holds: assert property (
        (!control_reg[CTL_ENABLE_BIT] && !strobe_pulse_reg && !wd_rst)
        |=> $stable(count_reg))
        else $error("Counter moved while disabled");

    // Counter steps by exactly one per tick while enabled
    a_count_steps: assert property (
        (control_reg[CTL_ENABLE_BIT] && tick && !strobe_pulse_reg && !wd_rst)
        |=> (count_reg == $past(count_reg) + 8'h01))
        else $error("Counter did not step by one");

    // Counter wraps from all ones to zero
    a_count_wraps: assert property (
        (control_reg[CTL_ENABLE_BIT] && tick && count_reg == 8'hff
         && !strobe_pulse_reg && !wd_rst) |=> (count_reg == RST_ZERO))
        else $error("Counter failed to wrap");

    // Counter reads back through the read port
    a_count_read: assert property (
        (RD_STB && ADDR == OFS_COUNT) |=> (RDATA == $past(count_reg)))
        else $error("Counter value misread");

    // Rising edge of the tapped bit sets the timer flag
    a_timer_flag_set: assert property (
        (timer_evt && !wd_rst) |=> irq_flag_reg[IRQ_TIMER_BIT])
        else $error("Timer flag not set");

    // Interrupt pin follows the masked flags one edge later
    a_irq_level: assert property (
        IRQ == $past(|(irq_flag_reg & irq_ena_reg)))
        else $error("Interrupt pin disagrees with flags");

    // Watchdog stays quiet with its pin low
    a_wd_off_no_reset: assert property (
        (!WDOG_EN_PIN && wd_state_reg != WD_RESET) |=> !WDOG_RESET_OUT)
        else $error("Watchdog reset while disabled");

    // Pin low stops a running watchdog
    a_wd_pin_stops: assert property (
        (!WDOG_EN_PIN && wd_state_reg == WD_RUN) |=> (wd_state_reg == WD_IDLE))
        else $error("Watchdog kept running with pin low");

    // Reset out is a single pulse that sets the timeout flag
    a_wd_timeout_flag: assert property (
        WDOG_RESET_OUT |-> (status_reg[STS_TO_BIT] && wd_rst))
        else $error("Timeout flag missing on watchdog reset");
    a_wd_pulse_single: assert property (
        WDOG_RESET_OUT |=> !WDOG_RESET_OUT)
        else $error("Watchdog reset pulse too long");

    // Clear instruction restarts counter two
    a_wd_clear_restarts: assert property (
        (WDOG_CLEAR && wd_state_reg == WD_RUN) |=> (wd_cnt_reg == '0))
        else $error("Watchdog clear ignored");

    // Counter two moves only on a rising edge of the tapped stage
    a_wd_tap_edge: assert property (
        (wd_state_reg == WD_RUN && !WDOG_CLEAR && !wd_tap_now)
        |=> $stable(wd_cnt_reg))
        else $error("Counter two moved without a tap edge");

    // Watchdog reset loads control, counter, flags and enables
    a_wd_reset_values: assert property (
        wd_rst |=> (control_reg == RST_CONTROL && count_reg == RST_ZERO
                    && irq_ena_reg == RST_ZERO))
        else $error("Watchdog reset values wrong");
    a_wd_status_kept: assert property (
        wd_rst |=> (status_reg == $past(status_reg)
                    && irq_flag_reg == RST_ZERO))
        else $error("Status or flags wrong on watchdog reset");

    // Main scenarios reached
    c_timer_irq: cover property (timer_evt ##[1:3] IRQ);
    c_wd_reset: cover property ($rose(WDOG_RESET_OUT));
    c_strobe: cover property (strobe_pulse_reg);
    c_wd_clear: cover property (WDOG_CLEAR && wd_state_reg == WD_RUN);
    c_count_wrap: cover property (count_reg == 8'hff ##1 count_reg == 8'h00);
endmodule : ttw_top

// ==== include/ttw_pkg.sv ====
// Constants, register map and state types for the tick timer and watchdog.
// Assumes a single 200 MHz system clock and an active-low asynchronous reset.
// How it works
// - Writing zero to control bit 7 pulses a counter reset once.
// - Control bit 7 always reads back as one after the pulse.
// - Counter advances only while count enable is one; otherwise holds.
// - Interrupt tap select n picks counter bit n as interrupt source.
// - Counter value register is read-only; writes are ignored.
// - Watchdog runs only while its enable pin is high.
// - Counter two overflow asserts reset out and sets timeout flag.
// - Watchdog clear instruction restarts the second watchdog counter.
// - Watchdog tap select n picks prescaler stage bit n for counter two.
// - Watchdog reset loads control with 0x80 and clears counter value.
// - Watchdog reset sets timeout, keeps other status; clears flags, enables.
// - External reset clears status, interrupt flags and interrupt enables.
// - External reset loads control with 0x80 and clears counter value.
package ttw_pkg;
    // Register offsets
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_IRQ_FLG = 8'h06;
    localparam logic [7:0] OFS_IRQ_ENA = 8'h07;
    localparam logic [7:0] OFS_COUNT   = 8'h0c;
    localparam logic [7:0] OFS_CONTROL = 8'h0d;
    // Control field positions
    localparam int CTL_STROBE_BIT = 7;
    localparam int CTL_WTAP_LSB   = 4;
    localparam int CTL_ENABLE_BIT = 3;
    localparam int CTL_ITAP_LSB   = 0;
    // Status field positions
    localparam int STS_PD_BIT = 4;
    localparam int STS_TO_BIT = 3;
    // Interrupt flag positions
    localparam int IRQ_TIMER_BIT = 0;
    localparam int IRQ_WDOG_BIT  = 1;
    // Reset values
    localparam logic [7:0] RST_CONTROL = 8'h80;
    localparam logic [7:0] RST_STATUS  = 8'h00;
    localparam logic [7:0] RST_ZERO    = 8'h00;
    // Timebase and watchdog reset pulse, in ns and derived cycles
    localparam int CLK_PERIOD_NS   = 5;
    localparam int TICK_PERIOD_NS  = 1000;
    localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int WRST_PULSE_NS   = 20;
    localparam int WRST_CYCLES     = (WRST_PULSE_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    // Watchdog sequencer states
    typedef enum logic [2:0] {
        WD_IDLE  = 3'b001,
        WD_RUN   = 3'b010,
        WD_RESET = 3'b100
    } ttw_wd_state_t;
endpackage : ttw_pkg

// ==== tb/tb_top.sv ====
// Self-checking bench for the tick timer and watchdog.
// Assumes TICK_DIV=2 and WDOG_WIDTH=2 so the long counts stay short.
`timescale 1ns/1ps
module tb_top;
    import ttw_pkg::*;
    logic       clk = 1'b0, nrst = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic       wd_pin = 1'b0, clear_on = 1'b0, wd_clear, wd_rst, irq;
    logic [7:0] addr = 8'h00, wdata = 8'h00, clear_gap = 8'h02, rdata;
    int         fails = 0, cmp_count = 0, cyc = 0, wrst_seen;

    ttw_top #(.TICK_DIV(2), .WDOG_WIDTH(2)) dut (
        .CLK_SYS(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
        .WDOG_EN_PIN(wd_pin), .WDOG_CLEAR(wd_clear),
        .WDOG_RESET_OUT(wd_rst), .IRQ(irq));
    ttw_core_model core (.clk_sys(clk), .nrst(nrst), .clear_on(clear_on),
        .clear_gap(clear_gap), .wdog_reset_out(wd_rst),
        .wdog_clear(wd_clear), .wrst_seen(wrst_seen));

    // 200 MHz clock and a cycle ceiling against hangs
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic chk8(input string nm, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8
    task automatic chk1(input string nm, input logic e, g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1
    task automatic chkr(input string nm, input int lo, hi, v);
        cmp_count++;
        if (v < lo || v > hi) begin
            fails++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
        end
    endtask : chkr
    // Bus cycles start off the edge; strobes last exactly one cycle
    task automatic wr(input logic [7:0] a, d);
        addr <= a; wdata <= d; wr_stb <= 1'b1;
        @(posedge clk); wr_stb <= 1'b0;
        @(posedge clk); #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr <= a; rd_stb <= 1'b1;
        @(posedge clk); rd_stb <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic rdchk(input string nm, input logic [7:0] a, e);
        logic [7:0] d;
        rd(a, d);
        chk8(nm, e, d);
    endtask : rdchk
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles

    task automatic t_reset;
        rdchk("control", OFS_CONTROL, RST_CONTROL);
        rdchk("count", OFS_COUNT, RST_ZERO);
        rdchk("status", OFS_STATUS, RST_STATUS);
        rdchk("flags", OFS_IRQ_FLG, 8'h00);
        rdchk("enables", OFS_IRQ_ENA, 8'h00);
        rdchk("unmapped", 8'h3f, 8'h00);
        chk1("irq idle", 1'b0, irq);
        $display("test reset done");
    endtask : t_reset

    task automatic t_count;
        logic [7:0] a, b;
        wr(OFS_CONTROL, 8'h88);
        cycles(20);
        wr(OFS_CONTROL, 8'h80);
        rd(OFS_COUNT, a);
        cycles(10);
        rd(OFS_COUNT, b);
        chkr("count moved", 8, 16, int'(a));
        chk8("held count", a, b);
        wr(OFS_COUNT, 8'h55);
        rdchk("count after write", OFS_COUNT, a);
        wr(OFS_CONTROL, 8'h00);
        rdchk("count cleared", OFS_COUNT, 8'h00);
        rdchk("strobe reads one", OFS_CONTROL, 8'h80);
        $display("test count done");
    endtask : t_count

    task automatic t_wrap;
        logic [7:0] prev, cur;
        logic       wrapped;
        wrapped = 1'b0;
        wr(OFS_CONTROL, 8'h08);
        addr <= OFS_COUNT; rd_stb <= 1'b1;
        @(posedge clk); #1 prev = rdata;
        for (int i = 0; i < 600; i++) begin
            @(posedge clk); #1 cur = rdata;
            chk1("step by one", 1'b1, 8'(cur - prev) <= 8'h01);
            if (prev == 8'hff && cur == 8'h00) wrapped = 1'b1;
            prev = cur;
        end
        rd_stb <= 1'b0;
        chk1("wrap seen", 1'b1, wrapped);
        wr(OFS_CONTROL, 8'h80);
        $display("test wrap done");
    endtask : t_wrap

    task automatic t_irq;
        int t;
        wr(OFS_IRQ_ENA, 8'h01);
        for (int n = 0; n < 8; n++) begin
            wr(OFS_CONTROL, 8'h00);
            wr(OFS_IRQ_FLG, 8'hff);
            chk1("irq before", 1'b0, irq);
            wr(OFS_CONTROL, 8'h88 | 8'(n));
            t = 0;
            while (irq !== 1'b1 && t < 600) begin
                @(posedge clk); #1 t++;
            end
            chkr("irq delay", 2**(n+1) - 4, 2**(n+1) + 6, t);
            wr(OFS_CONTROL, 8'h80 | 8'(n));
            rdchk("timer flag", OFS_IRQ_FLG, 8'h01);
            wr(OFS_IRQ_ENA, 8'h00);
            chk1("irq masked", 1'b0, irq);
            wr(OFS_IRQ_ENA, 8'h01);
            chk1("irq unmasked", 1'b1, irq);
            wr(OFS_IRQ_FLG, 8'h01);
            chk1("irq cleared", 1'b0, irq);
        end
        $display("test irq done");
    endtask : t_irq

    task automatic t_wdog;
        int w0, t;
        wd_pin <= 1'b0;
        wr(OFS_CONTROL, 8'h80);
        w0 = wrst_seen;
        cycles(100);
        chkr("resets pin low", 0, 0, wrst_seen - w0);
        clear_gap <= 8'h02; clear_on <= 1'b1; wd_pin <= 1'b1;
        cycles(150);
        chkr("resets with clears", 0, 0, wrst_seen - w0);
        clear_gap <= 8'd20;
        cycles(60);
        chkr("slow clears", 1, 30, wrst_seen - w0);
        for (int n = 0; n < 8; n++) begin
            clear_on <= 1'b0; clear_gap <= 8'h02; wd_pin <= 1'b0;
            cycles(WRST_CYCLES + 2); // Let a reset in progress run out
            wr(OFS_STATUS, 8'h10);
            wr(OFS_IRQ_ENA, 8'h01);
            wr(OFS_CONTROL, 8'h80 | 8'(n << 4));
            wd_pin <= 1'b1;
            t = 0;
            while (wd_rst !== 1'b1 && t < 3000) begin
                @(posedge clk); #1 t++;
            end
            clear_on <= 1'b1;
            chkr("wdog delay", 2**(n+2), 2**(n+3) + 8, t);
            chk1("reset pulse", 1'b1, wd_rst);
            cycles(WRST_CYCLES + 2);
            rdchk("status after", OFS_STATUS, 8'h18);
            rdchk("control after", OFS_CONTROL, RST_CONTROL);
            rdchk("count after", OFS_COUNT, RST_ZERO);
            rdchk("enables after", OFS_IRQ_ENA, 8'h00);
            rdchk("flags after", OFS_IRQ_FLG, 8'h00);
        end
        clear_on <= 1'b0; wd_pin <= 1'b0;
        $display("test watchdog done");
    endtask : t_wdog

    task automatic t_ext_reset;
        wr(OFS_IRQ_ENA, 8'hff);
        wr(OFS_CONTROL, 8'h88);
        cycles(10);
        chk1("irq pre reset", 1'b1, irq);
        nrst <= 1'b0;
        cycles(2);
        chk1("irq in reset", 1'b0, irq);
        nrst <= 1'b1;
        cycles(1);
        rdchk("status ext", OFS_STATUS, RST_STATUS);
        rdchk("enables ext", OFS_IRQ_ENA, 8'h00);
        rdchk("flags ext", OFS_IRQ_FLG, 8'h00);
        rdchk("count ext", OFS_COUNT, RST_ZERO);
        rdchk("control ext", OFS_CONTROL, RST_CONTROL);
        $display("test external reset done");
    endtask : t_ext_reset

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        cycles(1);
        t_reset();
        t_count();
        t_wrap();
        t_irq();
        t_wdog();
        t_ext_reset();
        end_of_test();
    end
endmodule : tb_top

// ==== tb/ttw_core_model.sv ====
// Core-side partner: issues watchdog clear pulses and takes watchdog resets.
// Assumes the CLK_SYS domain; clears only while the bench enables them.
`timescale 1ns/1ps
module ttw_core_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // Bench control
    input  wire logic       clear_on,
    input  wire logic [7:0] clear_gap,
    // Device signals
    input  wire logic       wdog_reset_out,
    output logic            wdog_clear,
    output int              wrst_seen
);
    int gap_cnt;
    // One clear pulse every clear_gap + 1 cycles; a watchdog reset restarts the core
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wdog_clear <= 1'b0;
            gap_cnt    <= 0;
            wrst_seen  <= 0;
        end else if (wdog_reset_out) begin
            wdog_clear <= 1'b0;
            gap_cnt    <= 0;
            wrst_seen  <= wrst_seen + 1;
        end else if (clear_on && gap_cnt >= int'(clear_gap)) begin
            wdog_clear <= 1'b1;
            gap_cnt    <= 0;
        end else begin
            wdog_clear <= 1'b0;
            gap_cnt    <= gap_cnt + 1;
        end
    end
endmodule : ttw_core_model
